// ---- bench/bst_properties.sv ----
/*
 Concurrent checks on the scan-control outputs of bst_top.
 Assumes one aclk domain and aresetn synchronous, active low.
*/
`default_nettype none
module bst_properties (
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic [3:0] tap_state,
   input wire logic       tdo_enable_n,
   input wire logic       tdo_path_choice,
   input wire logic       instr_reg_clock,
   input wire logic       instr_reg_shift_n,
   input wire logic       instr_reg_hold_n,
   input wire logic       data_reg_clock,
   input wire logic       data_reg_shift_n,
   input wire logic       data_reg_hold_n,
   input wire logic       instr_reset_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========================================================
   // Controller outputs against the state code
   // Exit-1 allowed: enable drops at the next TCK fall
   a_en_in_shift: assert property (!tdo_enable_n |-> tap_state inside {1, 2, 9, 10})
      else $error("tdo enable outside shift");
   a_dr_path_low: assert property (tap_state inside {0, 1, 2, 3} |-> !tdo_path_choice)
      else $error("path high in data scan");
   a_ir_path_high: assert property (tap_state inside {8, 9, 10, 11} |-> tdo_path_choice)
      else $error("path low in instruction scan");
   a_ir_scan_quiet: assert property (tap_state inside {8, 9, 10, 11, 14} |->
      !data_reg_clock && data_reg_shift_n && data_reg_hold_n)
      else $error("data controls active in instruction scan");
   a_dr_scan_quiet: assert property (tap_state inside {0, 1, 2, 3, 6} |->
      !instr_reg_clock && instr_reg_shift_n && instr_reg_hold_n)
      else $error("instruction controls active in data scan");
   a_pause_dr: assert property (tap_state == 4'h3 |-> !data_reg_clock)
      else $error("data clock in pause");
   a_pause_ir: assert property (tap_state == 4'hB |-> !instr_reg_clock)
      else $error("instruction clock in pause");
   a_ir_hold_up: assert property ($rose(instr_reg_hold_n) |-> tap_state inside {12, 13})
      else $error("instruction hold rose elsewhere");
   a_dr_hold_up: assert property ($rose(data_reg_hold_n) |-> tap_state inside {5, 12})
      else $error("data hold rose elsewhere");
   a_shift_start: assert property ($fell(data_reg_shift_n) |->
      tap_state == 4'h2 && !data_reg_hold_n)
      else $error("data shift began outside shift");
   a_rst_release: assert property ($rose(instr_reset_n) |-> tap_state == 4'hC)
      else $error("reset output rose outside idle");
   a_rst_enter: assert property ($fell(instr_reset_n) |-> tap_state == 4'hF)
      else $error("reset output fell outside reset");
   a_reset_outs: assert property (tap_state == 4'hF && !instr_reset_n |->
      {instr_reg_clock, data_reg_clock, instr_reg_hold_n, data_reg_hold_n,
       instr_reg_shift_n, data_reg_shift_n, tdo_path_choice, tdo_enable_n} == 8'h0F)
      else $error("outputs wrong in reset state");
endmodule // bst_properties
`default_nettype wire

// ---- bench/bst_tester.sv ----
/*
 Tester model on the scan pins: TCK period 160 ns, still between frames.
 Assumes the caller waits for its tasks to finish.
*/
`default_nettype none
module bst_tester (
   output var logic tck,
   output var logic tms,
   output var logic tdi
);
   timeunit 1ns;
   timeprecision 1ps;
   int i;
   initial begin
      tck = 0;
      tms = 1;
      tdi = 0;
   end
   // TDI toggles outside shifts so no stale level is mistaken for data
   task step(input logic m, input logic d, input logic sh);
      tms = m;
      tdi = sh ? d : ~tdi;
      #80 tck = 1;
      #80 tck = 0;
   endtask
   task seq(input logic [15:0] p, input int n);
      #7;
      for (i = 0; i < n; i++) step(p[i], 1'b0, 1'b0);
   endtask
   task dr_scan(input logic [7:0] b, input int n);
      #7;
      step(1, 0, 0);
      step(0, 0, 0);
      step(0, 0, 0);
      for (i = 0; i < n; i++) step(i == n - 1, b[i], 1);
   endtask
   task dr_end;
      seq(16'h0001, 2);
   endtask
endmodule // bst_tester
`default_nettype wire

// ---- bench/testbench.sv ----
/*
 Self-checking bench for bst_top, with tester model and bus master.
 Assumes core/ is on the include path.
*/
`include "bst_map.vh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 0, aresetn = 0, test_reset_n = 1, pin_in_a = 0, core_out_b = 0;
   logic bidir_out_in = 0, bidir_pin_in = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, c;
   logic [31:0] s_axi_wdata = 0, rd;
   logic [7:0] b;
   logic [1:0] r;
   logic lp, lb;
   int error_cnt = 0, cmp_count = 0, k, n;
   wire logic tck, tms, tdi, core_in_a, pin_out_b, bidir_out_drive, tdo, tdo_enable_n;
   wire logic tdo_path_choice, instr_reg_clock, instr_reg_shift_n, instr_reg_hold_n;
   wire logic data_reg_clock, data_reg_shift_n, data_reg_hold_n, instr_reset_n;
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire logic [3:0] tap_state;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   wire logic [7:0] outs = {instr_reg_clock, data_reg_clock, instr_reg_hold_n,
      data_reg_hold_n, instr_reg_shift_n, data_reg_shift_n, tdo_path_choice, tdo_enable_n};
   always #10 aclk = ~aclk;
   bst_tester u_tst (.tck, .tms, .tdi);
   bst_top u_dut (.aclk, .aresetn, .tck, .tms, .tdi, .test_reset_n, .instr_serial_out(1'b0),
      .pin_in_a, .core_out_b, .bidir_out_in, .bidir_pin_in, .core_in_a, .pin_out_b,
      .bidir_out_drive, .tdo, .tdo_enable_n, .tdo_path_choice, .instr_reg_clock,
      .instr_reg_shift_n, .instr_reg_hold_n, .data_reg_clock, .data_reg_shift_n,
      .data_reg_hold_n, .instr_reset_n, .tap_state, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   // ==========================================================
   // Checking and bus tasks
   function automatic logic [3:0] shifted(input logic [3:0] s, input logic [7:0] d, input int m);
      for (int j = 0; j < m; j++) s = {s[2:0], d[j]};
      return s;
   endfunction
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task print_verdict;
      $display("mismatches %0d of %0d compares", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      int t;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      for (t = 0; t < 40; t++) begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
         if (s_axi_bvalid === 1'b1) break;
      end
      r = s_axi_bresp;
      s_axi_bready <= 0;
      if (t == 40) error_cnt++;
      if (t == 40) print_verdict;
   endtask
   task rdr(input logic [3:0] a);
      int t;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      for (t = 0; t < 40; t++) begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
         if (s_axi_rvalid === 1'b1) break;
      end
      rd = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
      if (t == 40) error_cnt++;
      if (t == 40) print_verdict;
   endtask
   // Room for the pin synchronisers
   task settle;
      repeat (10) @(posedge aclk);
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      k = $urandom(32'h52514BD3);
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      settle;
      chk("outs", 8'h0F, outs);
      chk("state", 4'hF, tap_state);
      rdr(`BST_OFS_CTRL);
      chk("ctrl", `BST_CTRL_RST, rd);
      rdr(4'hC);
      chk("rresp", `BST_RESP_SLVERR, r);
      wr(4'hC, 1);
      chk("bresp", `BST_RESP_SLVERR, r);
      u_tst.seq(16'h0000, 1);
      settle;
      chk("irst", 1, instr_reset_n);
      rdr(`BST_OFS_STATUS);
      chk("status", 32'h1C, rd & 32'h1F);
      wr(`BST_OFS_CTRL, 1);
      for (k = 1; k < 9; k++) begin
         n = (k - 1) % 4 + 1;
         @(posedge aclk);
         {pin_in_a, core_out_b, bidir_out_in, bidir_pin_in} <= 4'($urandom);
         settle;
         b = 8'($urandom);
         c = shifted({bidir_pin_in, bidir_out_in, core_out_b, pin_in_a}, b, n);
         u_tst.dr_scan(b, n);
         settle;
         if (k > 1) chk("held", {lb, lp}, {bidir_out_drive, pin_out_b});
         chk("tdo", c[3], tdo);
         u_tst.dr_end;
         settle;
         chk("pin_out", c[1], pin_out_b);
         chk("drive", c[2], bidir_out_drive);
         rdr(`BST_OFS_CELLS);
         chk("cells", {c[3], c[1], c[0], 1'b0}, rd & 32'hE);
         lp = c[1];
         lb = c[2];
      end
      u_tst.seq(16'h0003, 4);
      settle;
      chk("ir_shift", 3'b100, {tdo_path_choice, tdo_enable_n, data_reg_clock});
      chk("dr_idle", 2'b11, {data_reg_shift_n, data_reg_hold_n});
      u_tst.seq(16'h00D2, 8);
      settle;
      chk("ir_upd", 5'h1D, {instr_reg_hold_n, tap_state});
      u_tst.seq(16'h00A8, 8);
      settle;
      chk("dr_exit", 4'h3, {tdo_path_choice, instr_reg_clock, instr_reg_shift_n,
         instr_reg_hold_n});
      u_tst.dr_end;
      settle;
      chk("dr_upd", 1, data_reg_hold_n);
      wr(`BST_OFS_CTRL, 0);
      for (k = 0; k < 6; k++) begin
         @(posedge aclk);
         {core_out_b, bidir_out_in} <= 2'($urandom);
         @(posedge aclk);
         chk("pass", {core_out_b, bidir_out_in}, {pin_out_b, bidir_out_drive});
      end
      chk("core_in", pin_in_a, core_in_a);
      u_tst.seq(16'h001F, 5);
      settle;
      chk("irst_low", 0, instr_reset_n);
      chk("outs_rst", 8'h0F, outs);
      u_tst.seq(16'h0000, 1);
      u_tst.dr_scan(8'h05, 3);
      @(posedge aclk);
      test_reset_n <= 0;
      settle;
      chk("trst", 4'hF, tap_state);
      test_reset_n <= 1;
      print_verdict;
   end
endmodule // testbench
bind bst_top bst_properties u_props (.aclk, .aresetn, .tap_state, .tdo_enable_n,
   .tdo_path_choice, .instr_reg_clock, .instr_reg_shift_n, .instr_reg_hold_n,
   .data_reg_clock, .data_reg_shift_n, .data_reg_hold_n, .instr_reset_n);
`default_nettype wire

// ---- core/bst_map.vh ----
/*
 Boundary-scan block constants: state codes, offsets, fields, resets.
 Assumes it is included once by the design file.
*/
`ifndef BST_MAP_VH
`define BST_MAP_VH

// ==========================================================
// Controller state codes
`define BST_EXIT2_DR    4'h0
`define BST_EXIT1_DR    4'h1
`define BST_SHIFT_DR    4'h2
`define BST_PAUSE_DR    4'h3
`define BST_SEL_IR      4'h4
`define BST_UPDATE_DR   4'h5
`define BST_CAPTURE_DR  4'h6
`define BST_SEL_DR      4'h7
`define BST_EXIT2_IR    4'h8
`define BST_EXIT1_IR    4'h9
`define BST_SHIFT_IR    4'hA
`define BST_PAUSE_IR    4'hB
`define BST_IDLE        4'hC
`define BST_UPDATE_IR   4'hD
`define BST_CAPTURE_IR  4'hE
`define BST_RESET_ST    4'hF

// ==========================================================
// Register offsets (byte addresses)
`define BST_ADDR_W      4
`define BST_OFS_CTRL    4'h0
`define BST_OFS_STATUS  4'h4
`define BST_OFS_CELLS   4'h8

// ==========================================================
// Field positions
`define BST_CTRL_MUX    0

// ==========================================================
// Reset values and bus answers
`define BST_CTRL_RST    1'h0
`define BST_RESP_OKAY   2'h0
`define BST_RESP_SLVERR 2'h2
`define BST_SYNC_W      6

`endif

// ---- core/bst_top.v ----
/*
 Boundary-scan test access port controller with a four-bit boundary
 register: an observe-only cell, an observe-and-control cell and a
 bidirectional cell pair, plus an AXI4-Lite register slave.
 Assumes the tester's TCK, TMS, TDI, test reset and boundary pin inputs
 are asynchronous to aclk, and that TCK is far slower than aclk.
*/
// Notes on behaviour
// - pause states gate off the register clock
// - update-IR raises instruction hold, then idle
// - update-DR raises data hold
// - serial output enabled only in shift states
// - path high for IR scan, low DR
// - idle register's clock low, shift/hold high
// - first DR clock captures, then shift pulses
// - reset output rises on fall after idle
// - reset output falls on fall after reset
// - reset state fixes all outputs to defaults
// - observe cell captures input when shift high
// - observe cell shifts serial input when low
// - observe cell has no mux, no hold
// - control cell passes input when mux low
// - control cell captures input on clock
// - control cell shifts serial input on clock
// - hold latch keeps output during scan
// - hold rise updates output from flop
// - control cell observes and controls signal
// - cells chained serially, controls shared
// - bidir pair joins observe and control
// - bidir pair offers no internal test
// - state on TCK rise, outputs on fall
// - reset state all ones, idle 1100
`include "bst_map.vh"
`default_nettype none

// ==========================================================
// Observe-only cell
module bst_observe_cell (
   input  wire aclk,
   input  wire aresetn,
   input  wire clk_rise,
   input  wire shift_n,
   input  wire cell_in,
   input  wire serial_in,
   output reg  serial_out
);
   // No mux and no hold input: it cannot drive anything
   always @(posedge aclk) begin
      if (!aresetn) begin
         serial_out <= 1'b0;
      end else if (clk_rise) begin
         if (shift_n) begin
            serial_out <= cell_in;
         end else begin
            serial_out <= serial_in;
         end
      end
   end
endmodule // bst_observe_cell

// ==========================================================
// Observe-and-control cell
module bst_observe_control_cell (
   input  wire aclk,
   input  wire aresetn,
   input  wire clk_rise,
   input  wire shift_n,
   input  wire hold_n,
   input  wire mux_ctrl,
   input  wire cell_in,
   input  wire serial_in,
   output wire serial_out,
   output wire cell_out
);
   reg  shift_flop_q;
   reg  hold_latch_q;
   wire latch_out;

   always @(posedge aclk) begin
      if (!aresetn) begin
         shift_flop_q <= 1'b0;
      end else if (clk_rise && !hold_n) begin
         if (shift_n) begin
            shift_flop_q <= cell_in;
         end else begin
            shift_flop_q <= serial_in;
         end
      end
   end

   // Latch as a flop plus bypass, open while hold is high
   always @(posedge aclk) begin
      if (!aresetn) begin
         hold_latch_q <= 1'b0;
      end else if (hold_n) begin
         hold_latch_q <= shift_flop_q;
      end
   end

   assign latch_out  = hold_n ? shift_flop_q : hold_latch_q;
   assign cell_out   = mux_ctrl ? latch_out : cell_in;
   assign serial_out = shift_flop_q;
endmodule // bst_observe_control_cell

// ==========================================================
// Bidirectional pair: observe part on the pin, control part on the drive
module bst_bidir_cell_pair (
   input  wire aclk,
   input  wire aresetn,
   input  wire clk_rise,
   input  wire shift_n,
   input  wire hold_n,
   input  wire mux_ctrl,
   input  wire bidir_out_in,
   input  wire bidir_pin_in,
   input  wire serial_in,
   output wire serial_out,
   output wire bidir_out_drive
);
   wire mid;

   // Control part first in the chain, observe part last
   bst_observe_control_cell u_ctl (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .clk_rise   (clk_rise),
      .shift_n    (shift_n),
      .hold_n     (hold_n),
      .mux_ctrl   (mux_ctrl),
      .cell_in    (bidir_out_in),
      .serial_in  (serial_in),
      .serial_out (mid),
      .cell_out   (bidir_out_drive)
   );

   // Pin side is observed only, so core input cannot be forced
   bst_observe_cell u_obs (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .clk_rise   (clk_rise),
      .shift_n    (shift_n),
      .cell_in    (bidir_pin_in),
      .serial_in  (mid),
      .serial_out (serial_out)
   );
endmodule // bst_bidir_cell_pair

// ==========================================================
// Top: controller, boundary register and register slave
module bst_top (
   input  wire                   aclk,
   input  wire                   aresetn,
   input  wire                   tck,
   input  wire                   tms,
   input  wire                   tdi,
   input  wire                   test_reset_n,
   input  wire                   instr_serial_out,
   input  wire                   pin_in_a,
   input  wire                   core_out_b,
   input  wire                   bidir_out_in,
   input  wire                   bidir_pin_in,
   output wire                   core_in_a,
   output wire                   pin_out_b,
   output wire                   bidir_out_drive,
   output reg                    tdo,
   output reg                    tdo_enable_n,
   output reg                    tdo_path_choice,
   output reg                    instr_reg_clock,
   output reg                    instr_reg_shift_n,
   output reg                    instr_reg_hold_n,
   output reg                    data_reg_clock,
   output reg                    data_reg_shift_n,
   output reg                    data_reg_hold_n,
   output reg                    instr_reset_n,
   output reg  [3:0]             tap_state,
   input  wire [`BST_ADDR_W-1:0] s_axi_awaddr,
   input  wire                   s_axi_awvalid,
   output wire                   s_axi_awready,
   input  wire [31:0]            s_axi_wdata,
   input  wire [3:0]             s_axi_wstrb,
   input  wire                   s_axi_wvalid,
   output wire                   s_axi_wready,
   output reg  [1:0]             s_axi_bresp,
   output reg                    s_axi_bvalid,
   input  wire                   s_axi_bready,
   input  wire [`BST_ADDR_W-1:0] s_axi_araddr,
   input  wire                   s_axi_arvalid,
   output wire                   s_axi_arready,
   output reg  [31:0]            s_axi_rdata,
   output reg  [1:0]             s_axi_rresp,
   output reg                    s_axi_rvalid,
   input  wire                   s_axi_rready
);
   // =======================================================
   // Pin synchronisers: three flops, accept when stages 2 and 3 agree
   reg  [`BST_SYNC_W-1:0] sync1;
   reg  [`BST_SYNC_W-1:0] sync2;
   reg  [`BST_SYNC_W-1:0] sync3;
   reg  [`BST_SYNC_W-1:0] filt;
   wire [`BST_SYNC_W-1:0] raw;
   wire [`BST_SYNC_W-1:0] next_filt;
   genvar g;

   assign raw = {bidir_pin_in, pin_in_a, test_reset_n, tdi, tms, tck};

   generate
      for (g = 0; g < `BST_SYNC_W; g = g + 1) begin : g_sync
         assign next_filt[g] = (sync2[g] == sync3[g]) ? sync3[g] : filt[g];
         always @(posedge aclk) begin
            if (!aresetn) begin
               sync1[g] <= (g != 0);
               sync2[g] <= (g != 0);
               sync3[g] <= (g != 0);
               filt[g]  <= (g != 0);
            end else begin
               sync1[g] <= raw[g];
               sync2[g] <= sync1[g];
               sync3[g] <= sync2[g];
               filt[g]  <= next_filt[g];
            end
         end
      end
   endgenerate

   wire tck_rise = next_filt[0] & ~filt[0];
   wire tck_fall = ~next_filt[0] & filt[0];
   wire tms_s    = filt[1];
   wire tdi_s    = filt[2];
   wire trst_n_s = filt[3];

   // =======================================================
   // State register
   function [3:0] bst_next_state;
      input [3:0] st;
      input       m;
      begin
         case (st)
            `BST_RESET_ST:   bst_next_state = m ? `BST_RESET_ST : `BST_IDLE;
            `BST_IDLE:       bst_next_state = m ? `BST_SEL_DR : `BST_IDLE;
            `BST_SEL_DR:     bst_next_state = m ? `BST_SEL_IR : `BST_CAPTURE_DR;
            `BST_CAPTURE_DR: bst_next_state = m ? `BST_EXIT1_DR : `BST_SHIFT_DR;
            `BST_SHIFT_DR:   bst_next_state = m ? `BST_EXIT1_DR : `BST_SHIFT_DR;
            `BST_EXIT1_DR:   bst_next_state = m ? `BST_UPDATE_DR : `BST_PAUSE_DR;
            `BST_PAUSE_DR:   bst_next_state = m ? `BST_EXIT2_DR : `BST_PAUSE_DR;
            `BST_EXIT2_DR:   bst_next_state = m ? `BST_UPDATE_DR : `BST_SHIFT_DR;
            `BST_UPDATE_DR:  bst_next_state = m ? `BST_SEL_DR : `BST_IDLE;
            `BST_SEL_IR:     bst_next_state = m ? `BST_RESET_ST : `BST_CAPTURE_IR;
            `BST_CAPTURE_IR: bst_next_state = m ? `BST_EXIT1_IR : `BST_SHIFT_IR;
            `BST_SHIFT_IR:   bst_next_state = m ? `BST_EXIT1_IR : `BST_SHIFT_IR;
            `BST_EXIT1_IR:   bst_next_state = m ? `BST_UPDATE_IR : `BST_PAUSE_IR;
            `BST_PAUSE_IR:   bst_next_state = m ? `BST_EXIT2_IR : `BST_PAUSE_IR;
            `BST_EXIT2_IR:   bst_next_state = m ? `BST_UPDATE_IR : `BST_SHIFT_IR;
            `BST_UPDATE_IR:  bst_next_state = m ? `BST_SEL_DR : `BST_IDLE;
            default:         bst_next_state = `BST_RESET_ST;
         endcase
      end
   endfunction

   // Test reset needs no TCK edge
   always @(posedge aclk) begin
      if (!aresetn || !trst_n_s) begin
         tap_state <= `BST_RESET_ST;
      end else if (tck_rise) begin
         tap_state <= bst_next_state(tap_state, tms_s);
      end
   end

   // =======================================================
   // Output control flops, loaded on falling TCK
   wire st_dr_scan = (tap_state == `BST_CAPTURE_DR) || (tap_state == `BST_SHIFT_DR) ||
                     (tap_state == `BST_EXIT1_DR)   || (tap_state == `BST_PAUSE_DR) ||
                     (tap_state == `BST_EXIT2_DR);
   wire st_ir_scan = (tap_state == `BST_CAPTURE_IR) || (tap_state == `BST_SHIFT_IR) ||
                     (tap_state == `BST_EXIT1_IR)   || (tap_state == `BST_PAUSE_IR) ||
                     (tap_state == `BST_EXIT2_IR);
   wire st_reset   = (tap_state == `BST_RESET_ST);
   reg  dr_en;
   reg  ir_en;

   always @(posedge aclk) begin
      if (!aresetn || !trst_n_s) begin
         dr_en             <= 1'b0;
         ir_en             <= 1'b0;
         data_reg_shift_n  <= 1'b1;
         instr_reg_shift_n <= 1'b1;
         data_reg_hold_n   <= 1'b0;
         instr_reg_hold_n  <= 1'b0;
         tdo_path_choice   <= 1'b1;
         tdo_enable_n      <= 1'b1;
         instr_reset_n     <= 1'b0;
      end else if (tck_fall) begin
         // Clock runs in capture and shift only; pauses stop it
         dr_en             <= (tap_state == `BST_CAPTURE_DR) ||
                              (tap_state == `BST_SHIFT_DR);
         ir_en             <= (tap_state == `BST_CAPTURE_IR) ||
                              (tap_state == `BST_SHIFT_IR);
         // First pulse after capture sees shift high, later ones low
         data_reg_shift_n  <= (tap_state != `BST_SHIFT_DR);
         instr_reg_shift_n <= (tap_state != `BST_SHIFT_IR);
         // Holds low through the scan, high again in update
         data_reg_hold_n   <= !(st_dr_scan || st_reset);
         instr_reg_hold_n  <= !(st_ir_scan || st_reset);
         tdo_path_choice   <= !(st_dr_scan || (tap_state == `BST_UPDATE_DR));
         tdo_enable_n      <= !((tap_state == `BST_SHIFT_DR) ||
                                (tap_state == `BST_SHIFT_IR));
         instr_reset_n     <= !st_reset;
      end
   end

   // Gated clocks; enables move only while TCK is low
   always @(posedge aclk) begin
      if (!aresetn || !trst_n_s) begin
         data_reg_clock  <= 1'b0;
         instr_reg_clock <= 1'b0;
      end else begin
         data_reg_clock  <= next_filt[0] & dr_en;
         instr_reg_clock <= next_filt[0] & ir_en;
      end
   end

   // =======================================================
   // Boundary register: observe, control, bidir pair, in one chain
   reg  dr_clk_d;
   reg  test_mux_ctrl;
   wire dr_clk_rise = data_reg_clock & ~dr_clk_d;
   wire chain0;
   wire chain1;
   wire chain2;

   always @(posedge aclk) begin
      if (!aresetn) begin
         dr_clk_d <= 1'b0;
      end else begin
         dr_clk_d <= data_reg_clock;
      end
   end

   bst_observe_cell u_cell_a (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .clk_rise   (dr_clk_rise),
      .shift_n    (data_reg_shift_n),
      .cell_in    (filt[4]),
      .serial_in  (tdi_s),
      .serial_out (chain0)
   );
   assign core_in_a = filt[4];

   // Shared controls in parallel, serial data in series
   bst_observe_control_cell u_cell_b (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .clk_rise   (dr_clk_rise),
      .shift_n    (data_reg_shift_n),
      .hold_n     (data_reg_hold_n),
      .mux_ctrl   (test_mux_ctrl),
      .cell_in    (core_out_b),
      .serial_in  (chain0),
      .serial_out (chain1),
      .cell_out   (pin_out_b)
   );

   bst_bidir_cell_pair u_cell_c (
      .aclk            (aclk),
      .aresetn         (aresetn),
      .clk_rise        (dr_clk_rise),
      .shift_n         (data_reg_shift_n),
      .hold_n          (data_reg_hold_n),
      .mux_ctrl        (test_mux_ctrl),
      .bidir_out_in    (bidir_out_in),
      .bidir_pin_in    (filt[5]),
      .serial_in       (chain1),
      .serial_out      (chain2),
      .bidir_out_drive (bidir_out_drive)
   );

   always @(posedge aclk) begin
      if (!aresetn) begin
         tdo <= 1'b0;
      end else begin
         tdo <= tdo_path_choice ? instr_serial_out : chain2;
      end
   end

   // =======================================================
   // AXI4-Lite slave: address and data taken in either order
   reg                   aw_held;
   reg                   w_held;
   reg [`BST_ADDR_W-1:0] aw_addr;
   reg [31:0]            w_data;
   reg [3:0]             w_strb;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= {`BST_ADDR_W{1'b0}};
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `BST_RESP_OKAY;
         test_mux_ctrl <= `BST_CTRL_RST;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (aw_held && w_held) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr == `BST_OFS_CTRL) begin
               s_axi_bresp <= `BST_RESP_OKAY;
               if (w_strb[0]) begin
                  test_mux_ctrl <= w_data[`BST_CTRL_MUX];
               end
            end else if ((aw_addr == `BST_OFS_STATUS) || (aw_addr == `BST_OFS_CELLS)) begin
               s_axi_bresp <= `BST_RESP_OKAY;
            end else begin
               s_axi_bresp <= `BST_RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read side: status is live
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `BST_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `BST_RESP_OKAY;
         case (s_axi_araddr)
            `BST_OFS_CTRL:   s_axi_rdata <= {31'h0000_0000, test_mux_ctrl};
            `BST_OFS_STATUS: s_axi_rdata <= {21'h00_0000, instr_reg_shift_n,
                                             data_reg_shift_n, instr_reg_hold_n,
                                             data_reg_hold_n, tdo_path_choice,
                                             tdo_enable_n, instr_reset_n, tap_state};
            `BST_OFS_CELLS:  s_axi_rdata <= {28'h000_0000, chain2, chain1, chain0, tdo};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `BST_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // bst_top

`default_nettype wire
